// >>> decrement_branch_nonzero_core.sv
// Execution core for the indirect decrement-and-branch-if-nonzero forms
`default_nettype none
module dbni_core
  import dbni_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] opcode_b0,
  input wire logic [7:0] opcode_b1,
  input wire logic [7:0] branch_displacement,
  input wire logic [dbni_pkg::ADDR_W-1:0] pc_in,
  input wire logic [7:0] index_reg,
  input wire logic [7:0] program_status_word_in,
  output logic busy_q,
  output logic done_q,
  output logic unsupported_q,
  output logic branch_taken_q,
  output logic [dbni_pkg::ADDR_W-1:0] pc_q,
  output logic [7:0] program_status_word_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [dbni_pkg::ADDR_W-1:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  output logic mem_wbit8_q,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rbit8,
  input wire logic mem_has_bit8,
  input wire logic mem_ack
);
  import dbni_pkg::*;

  dbni_state_t state_q;
  dbni_state_t state_d;
  logic indexed_q;
  logic [6:0] offset_q;
  logic [7:0] index_q;
  logic [7:0] disp_q;
  logic [7:0] status_base_q;
  logic [ADDR_W-1:0] pc_base_q;
  logic [7:0] ptr_lo_q;
  logic [8:0] opnd9_q;
  logic [8:0] result_q;
  logic has_bit8_q;
  logic nonzero_q;

  // Opcode decode of the first two bytes
  wire logic first_ok;
  wire logic offset_form;
  wire logic indexed_form;
  wire logic legal;
  wire logic [5:0] selector;
  wire logic [ADDR_W-1:0] ptr_addr;
  assign first_ok = (opcode_b0 == OPC_DEC_BRANCH);
  assign offset_form = first_ok & opcode_b1[MODE_BIT];
  assign indexed_form = first_ok & ~opcode_b1[MODE_BIT] & opcode_b1[IDX_BIT];
  assign legal = offset_form | indexed_form;
  assign selector = opcode_b1[SEL_MSB:SEL_LSB];
  // offset form reads base pointer zero
  assign ptr_addr = indexed_form ? {{(ADDR_W-7){1'b0}}, selector, 1'b0} : BASE_ZERO_ADDR;

  // Operand address from the full pointer word
  wire logic [ADDR_W-1:0] opnd_addr;
  dbni_addr_gen u_addr (
    .pointer({mem_rdata, ptr_lo_q}),
    .indexed(indexed_q),
    .index_reg(index_q),
    .offset(offset_q),
    .addr(opnd_addr)
  );

  // Decrement straight off the read data so the write can follow the read ack
  wire logic [8:0] dec_result;
  wire logic dec_nonzero;
  dbni_dec9 u_dec (
    .value(mem_rdata),
    .has_bit8(mem_has_bit8),
    .bit8(mem_rbit8),
    .result(dec_result),
    .nonzero(dec_nonzero)
  );

  wire logic acked;
  wire logic result_nonzero;
  wire logic [ADDR_W-1:0] pc_fall;
  wire logic [ADDR_W-1:0] pc_branch;
  wire logic [7:0] status_next;
  assign acked = mem_req_q & mem_ack;
  // zero test on low byte only
  assign result_nonzero = nonzero_q;
  assign pc_fall = pc_base_q + PC_STEP;
  assign pc_branch = pc_fall + dbni_sext8(disp_q);
  // result bit 8 into the ninth-bit flag
  assign status_next = (status_base_q & ~(8'h01 << NINTH_FLAG_BIT)) | ({7'h00, result_q[8]} << NINTH_FLAG_BIT);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_idle: begin
        if (start && legal) begin
          state_d = st_ptr_lo;
        end
      end
      st_ptr_lo: begin
        if (acked) begin
          state_d = st_ptr_hi;
        end
      end
      st_ptr_hi: begin
        if (acked) begin
          state_d = st_opnd_rd;
        end
      end
      st_opnd_rd: begin
        if (acked) begin
          state_d = st_opnd_wr;
        end
      end
      st_opnd_wr: begin
        if (acked) begin
          state_d = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Instruction capture; the caller's values are only sampled at start
  always_ff @(posedge clk) begin
    if (reset) begin
      indexed_q <= 1'b0;
      offset_q <= 7'h00;
      index_q <= 8'h00;
      disp_q <= 8'h00;
      status_base_q <= 8'h00;
      pc_base_q <= 16'h0000;
    end else if (state_q == st_idle && start) begin
      indexed_q <= indexed_form;
      offset_q <= opcode_b1[OFF_MSB:0];
      index_q <= index_reg;
      disp_q <= branch_displacement;
      status_base_q <= program_status_word_in;
      pc_base_q <= pc_in;
    end
  end

  // Memory port sequencing: pointer low, pointer high, operand read, write back
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 8'h00;
      mem_wbit8_q <= 1'b0;
      ptr_lo_q <= 8'h00;
      opnd9_q <= 9'h000;
      result_q <= 9'h000;
      has_bit8_q <= 1'b0;
      nonzero_q <= 1'b0;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (start && legal) begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= ptr_addr;
          end
        end
        st_ptr_lo: begin
          if (acked) begin
            ptr_lo_q <= mem_rdata;
            mem_addr_q <= mem_addr_q + ADDR_ONE;
          end
        end
        st_ptr_hi: begin
          // operand address from pointer word and displacement
          if (acked) begin
            mem_addr_q <= opnd_addr;
          end
        end
        st_opnd_rd: begin
          if (acked) begin
            opnd9_q <= {mem_has_bit8 ? mem_rbit8 : 1'b1, mem_rdata};
            has_bit8_q <= mem_has_bit8;
            nonzero_q <= dec_nonzero;
            result_q <= dec_result;
            mem_we_q <= 1'b1;
            mem_wdata_q <= dec_result[7:0];
            mem_wbit8_q <= dec_result[8];
          end
        end
        st_opnd_wr: begin
          if (acked) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Completion: program counter, flag and branch outcome
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      unsupported_q <= 1'b0;
      branch_taken_q <= 1'b0;
      pc_q <= 16'h0000;
      program_status_word_q <= 8'h00;
    end else begin
      busy_q <= (state_d != st_idle);
      done_q <= 1'b0;
      unsupported_q <= (state_q == st_idle) && start && !legal;
      if (state_q == st_opnd_wr && acked) begin
        done_q <= 1'b1;
        branch_taken_q <= result_nonzero;
        pc_q <= result_nonzero ? pc_branch : pc_fall;
        // flag update for any operand width
        program_status_word_q <= status_next;
      end
    end
  end

  // Checks on the outputs against their causes

  ptr_area_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_ptr_lo) |-> (mem_addr_q < PTR_AREA_END))
    else $error("pointer fetch outside the pointer area");

  indexed_addr_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_ptr_hi && acked && indexed_q)
      |=> (mem_addr_q == {$past(mem_rdata), ptr_lo_q} + dbni_sext8(index_q)))
    else $error("indexed operand address wrong");

  offset_addr_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_ptr_hi && acked && !indexed_q)
      |=> (mem_addr_q == {$past(mem_rdata), ptr_lo_q} + dbni_sext7(offset_q)))
    else $error("offset operand address wrong");

  base_zero_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_idle && start && offset_form) |=> (mem_addr_q == BASE_ZERO_ADDR && !mem_we_q))
    else $error("offset form did not fetch base pointer zero");

  decode_reject_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_idle && start && !legal) |=> (unsupported_q && !mem_req_q && state_q == st_idle))
    else $error("unsupported encoding was executed");

  write_value_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_opnd_wr) |-> (mem_we_q && {mem_wbit8_q, mem_wdata_q} == opnd9_q - DEC_ONE))
    else $error("written value is not operand minus one");

  assumed_bit_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_opnd_wr && !has_bit8_q) |-> opnd9_q[8])
    else $error("missing ninth bit not taken as one");

  ninth_flag_a: assert property (@(posedge clk) disable iff (reset)
    done_q |-> (program_status_word_q[NINTH_FLAG_BIT] == result_q[8]))
    else $error("ninth-bit flag does not match result bit 8");

  taken_pc_a: assert property (@(posedge clk) disable iff (reset)
    (done_q && branch_taken_q) |-> (pc_q == pc_base_q + PC_STEP + dbni_sext8(disp_q)))
    else $error("branch target wrong");

  fall_pc_a: assert property (@(posedge clk) disable iff (reset)
    (done_q && !branch_taken_q) |-> (pc_q == pc_base_q + PC_STEP && result_q[7:0] == 8'h00))
    else $error("fall-through address wrong");

  zero_test_a: assert property (@(posedge clk) disable iff (reset)
    done_q |-> (branch_taken_q == (result_q[7:0] != 8'h00)))
    else $error("branch decision ignores low byte");

  sequence_len_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == st_idle && start && indexed_form)
      |=> (mem_addr_q == {{(ADDR_W-7){1'b0}}, $past(selector), 1'b0}) ##[1:1000] done_q)
    else $error("indexed instruction did not complete");
endmodule
`default_nettype wire

// >>> decrement_branch_nonzero_pkg.sv
// Shared constants and helpers for the decrement-and-branch-if-nonzero unit
`default_nettype none
package dbni_pkg;
  localparam int ADDR_W = 16;
  localparam logic [7:0] OPC_DEC_BRANCH = 8'h22;
  localparam int MODE_BIT = 7;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 6;
  localparam int IDX_BIT = 0;
  localparam int OFF_MSB = 6;
  localparam int NINTH_FLAG_BIT = 1;
  localparam logic [ADDR_W-1:0] PC_STEP = 16'h0003;
  localparam logic [ADDR_W-1:0] BASE_ZERO_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] PTR_AREA_END = 16'h0080;
  localparam logic [8:0] DEC_ONE = 9'h001;

  typedef enum logic [2:0] {
    st_idle,
    st_ptr_lo,
    st_ptr_hi,
    st_opnd_rd,
    st_opnd_wr
  } dbni_state_t;

  // Two's-complement widening of an 8-bit displacement
  function automatic logic [ADDR_W-1:0] dbni_sext8(input logic [7:0] v);
    dbni_sext8 = {{(ADDR_W-8){v[7]}}, v};
  endfunction

  // Two's-complement widening of a 7-bit displacement
  function automatic logic [ADDR_W-1:0] dbni_sext7(input logic [6:0] v);
    dbni_sext7 = {{(ADDR_W-7){v[6]}}, v};
  endfunction
endpackage
`default_nettype wire

// >>> decrement_branch_nonzero_units.sv
// Operand address adder and 9-bit decrementer for the decrement-and-branch unit
`default_nettype none
module dbni_addr_gen
  import dbni_pkg::*;
(
  input wire logic [dbni_pkg::ADDR_W-1:0] pointer,
  input wire logic indexed,
  input wire logic [7:0] index_reg,
  input wire logic [6:0] offset,
  output logic [dbni_pkg::ADDR_W-1:0] addr
);
  wire logic [ADDR_W-1:0] disp;
  assign disp = indexed ? dbni_sext8(index_reg) : dbni_sext7(offset);
  assign addr = pointer + disp;
endmodule

module dbni_dec9
  import dbni_pkg::*;
(
  input wire logic [7:0] value,
  input wire logic has_bit8,
  input wire logic bit8,
  output logic [8:0] result,
  output logic nonzero
);
  wire logic eff_bit8;
  // missing ninth bit reads as one
  assign eff_bit8 = has_bit8 ? bit8 : 1'b1;
  assign result = {eff_bit8, value} - DEC_ONE;
  assign nonzero = |result[7:0];
endmodule
`default_nettype wire

// >>> decrement_branch_nonzero_tb.sv
// Self-checking testbench for the decrement-and-branch-if-nonzero core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dbni_pkg::*;
  logic clk, reset, start, mem_rbit8, mem_has_bit8, mem_ack;
  logic [7:0] opcode_b0, opcode_b1, branch_displacement, index_reg, program_status_word_in, mem_rdata;
  logic [ADDR_W-1:0] pc_in, pc_q, mem_addr_q;
  logic busy_q, done_q, unsupported_q, branch_taken_q, mem_req_q, mem_we_q, mem_wbit8_q;
  logic [7:0] program_status_word_q, mem_wdata_q;
  logic [7:0] mem [0:255];
  logic [8:0] wr_seen;
  int error_cnt, n_compared, n_req;

  dbni_core uut (.clk, .reset, .start, .opcode_b0, .opcode_b1, .branch_displacement, .pc_in, .index_reg,
    .program_status_word_in, .busy_q, .done_q, .unsupported_q, .branch_taken_q, .pc_q, .program_status_word_q,
    .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_wbit8_q, .mem_rdata, .mem_rbit8, .mem_has_bit8,
    .mem_ack);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // One wait state per access; read data is scrambled outside the ack cycle
  always @(posedge clk) begin
    if (mem_req_q && mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_we_q) begin
        mem[mem_addr_q[7:0]] <= mem_wdata_q;
        wr_seen <= {mem_wbit8_q, mem_wdata_q};
      end
    end else if (mem_req_q) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr_q[7:0]];
      n_req <= n_req + 1;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic exec(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] d, input logic [15:0] pc,
    input logic [7:0] c, input logic [7:0] sw, input logic h9, input logic b8);
    int i;
    @(posedge clk);
    opcode_b0 <= b0;
    opcode_b1 <= b1;
    branch_displacement <= d;
    pc_in <= pc;
    index_reg <= c;
    program_status_word_in <= sw;
    mem_has_bit8 <= h9;
    mem_rbit8 <= b8;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if (done_q === 1'b1 || unsupported_q === 1'b1) break;
      @(posedge clk);
    end
    if (i == 40) begin
      error_cnt++;
      $display("CHECK FAILED completion expected 1 seen 0");
      finish_test();
    end
  endtask

  task automatic dec_case(input logic [7:0] b1, input logic [7:0] pa, input logic [15:0] ptr,
    input logic [7:0] c, input logic [7:0] oa, input logic [7:0] val, input logic h9, input logic b8,
    input logic [7:0] d, input logic [15:0] pc, input logic [7:0] sw, input logic [8:0] ew,
    input logic [15:0] epc, input logic etk, input logic [7:0] epsw);
    int r0;
    mem[pa] = ptr[7:0];
    mem[pa + 8'h01] = ptr[15:8];
    mem[oa] = val;
    r0 = n_req;
    exec(OPC_DEC_BRANCH, b1, d, pc, c, sw, h9, b8);
    chk("done", 16'h0001, {15'h0000, done_q});
    chk("busy", 16'h0000, {15'h0000, busy_q});
    chk("accesses", 16'h0004, 16'(n_req - r0));
    chk("written value", {7'h00, ew}, {7'h00, wr_seen});
    chk("operand byte", {8'h00, ew[7:0]}, {8'h00, mem[oa]});
    chk("pc", epc, pc_q);
    chk("taken", {15'h0000, etk}, {15'h0000, branch_taken_q});
    chk("status word", {8'h00, epsw}, {8'h00, program_status_word_q});
  endtask

  task automatic t_indexed_branch();
    // Top selector, negative index, 8-bit target, backward branch
    dec_case(8'h7f, 8'h7e, 16'h0090, 8'hf0, 8'h80, 8'h05, 1'b0, 1'b0, 8'hfa, 16'h1f03, 8'h00,
      9'h104, 16'h1f00, 1'b1, 8'h02);
    $display("indexed branch test done");
  endtask

  task automatic t_indexed_zero();
    // Result zero falls through; pc wraps past the top
    dec_case(8'h01, 8'h00, 16'h0040, 8'h7f, 8'hbf, 8'h01, 1'b0, 1'b0, 8'h10, 16'hfffe, 8'hfd,
      9'h100, 16'h0001, 1'b0, 8'hff);
    $display("indexed zero test done");
  endtask

  task automatic t_offset_nine();
    // Lowest offset, nine-bit target borrowing through bit 8; index register ignored
    dec_case(8'hc0, 8'h00, 16'h00c0, 8'h55, 8'h80, 8'h00, 1'b1, 1'b0, 8'h7f, 16'h0100, 8'h00,
      9'h1ff, 16'h0182, 1'b1, 8'h02);
    $display("offset nine-bit test done");
  endtask

  task automatic t_offset_eight();
    // Highest offset, 8-bit target: bit 8 input must be ignored and taken as one
    dec_case(8'hbf, 8'h00, 16'h0010, 8'h00, 8'h4f, 8'h00, 1'b0, 1'b1, 8'h80, 16'h0200, 8'h00,
      9'h0ff, 16'h0183, 1'b1, 8'h00);
    $display("offset eight-bit test done");
  endtask

  task automatic t_refused();
    logic [15:0] enc [2];
    int r0;
    enc[0] = 16'h2381;
    enc[1] = {OPC_DEC_BRANCH, 8'h02};
    foreach (enc[k]) begin
      r0 = n_req;
      exec(enc[k][15:8], enc[k][7:0], 8'h00, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0);
      chk("unsupported", 16'h0001, {15'h0000, unsupported_q});
      chk("no access", 16'h0000, 16'(n_req - r0));
    end
    $display("refused encoding test done");
  endtask

  initial begin
    reset = 1'b1;
    start = 1'b0;
    opcode_b0 = 8'h00;
    opcode_b1 = 8'h00;
    branch_displacement = 8'h00;
    pc_in = 16'h0000;
    index_reg = 8'h00;
    program_status_word_in = 8'h00;
    mem_rdata = 8'h00;
    mem_rbit8 = 1'b0;
    mem_has_bit8 = 1'b0;
    mem_ack = 1'b0;
    wr_seen = 9'h000;
    error_cnt = 0;
    n_compared = 0;
    n_req = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_indexed_branch();
    t_indexed_zero();
    t_offset_nine();
    t_offset_eight();
    t_refused();
    finish_test();
  end
endmodule
`default_nettype wire
